// File: dv/twm_slave_model.sv
// behavioural two-wire slave: acks its address, logs bytes, returns one byte on reads
// assumes wire levels with pull-ups, sampled on the system clock; never stretches
`timescale 1ns/10ps
module twm_slave_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic [7:0] rd_byte,
  output logic sda_pull,
  output logic [31:0] last4,
  output logic [7:0] nbytes,
  output logic [7:0] nstops
);
  logic scl_q, sda_q, first, rdm;
  logic [3:0] bcnt;
  logic [7:0] sh, tx;
  initial begin
    {scl_q, sda_q, first, rdm, sda_pull} = 5'h18;
    {bcnt, sh, tx, last4, nbytes, nstops} = '0;
  end
  always @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      bcnt <= 4'h0;
      first <= 1'b1;
      rdm <= 1'b0;
      sda_pull <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      nstops <= nstops + 8'h01;
      rdm <= 1'b0;
      sda_pull <= 1'b0;
    end else if (scl && !scl_q) begin
      if (bcnt < 4'h8) sh <= {sh[6:0], sda};
      // a master nack ends the read, so the line is freed for the stop
      if (bcnt == 4'h8 && rdm && !first && sda) rdm <= 1'b0;
      if (bcnt < 4'h9) bcnt <= bcnt + 4'h1;
    end else if (!scl && scl_q) begin
      if (bcnt == 4'h8) begin
        last4 <= {last4[23:0], sh};
        nbytes <= nbytes + 8'h01;
        if (first) rdm <= sh[0];
        sda_pull <= first || (!rdm && ack_en);
      end else if (bcnt == 4'h9) begin
        bcnt <= 4'h0;
        first <= 1'b0;
        tx <= rd_byte;
        sda_pull <= rdm && !rd_byte[7];
      end else begin
        sda_pull <= rdm && !first && !tx[3'(7 - bcnt)];
      end
    end
  end
endmodule

// File: dv/two_wire_master_regs_tb_top.sv
// self-checking bench for the two-wire master register block
// assumes one 20 MHz clock; the slave model and pull-ups form the bus
`timescale 1ns/10ps
module two_wire_master_regs_tb_top;
  import twm_pkg::*;
  logic clock, nrst, wr, rd, ack_en;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, v, last4;
  logic irq, scl_out, scl_oe, sda_out, sda_oe, sda_pull, scl_w, sda_w;
  logic [7:0] rd_byte, nbytes, nstops, n0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int lo_cnt = 0;
  int hi_cnt = 0;
  int low_run = 0;
  int high_run = 0;
  assign scl_w = scl_oe ? scl_out : 1'b1;
  assign sda_w = !sda_pull && (sda_oe ? sda_out : 1'b1);
  twm_regs i_twm_regs (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  twm_slave_model i_twm_slave_model (.clock(clock), .scl(scl_w), .sda(sda_w),
    .ack_en(ack_en), .rd_byte(rd_byte), .sda_pull(sda_pull), .last4(last4),
    .nbytes(nbytes), .nstops(nstops));
  initial clock = 1'b0;
  always #25 clock = ~clock;
  // run lengths of the pulled-low and released clock phases
  always @(posedge clock) begin
    cyc <= cyc + 1;
    lo_cnt <= scl_oe ? lo_cnt + 1 : 0;
    hi_cnt <= scl_oe ? 0 : hi_cnt + 1;
    if (!scl_oe && lo_cnt != 0) low_run <= lo_cnt;
    if (scl_oe && hi_cnt != 0) high_run <= hi_cnt;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
    input string msg);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
    chk(v & m, e, msg);
  endtask
  // stop seen on the wire within a bounded wait, then let status settle
  task automatic wait_stop;
    n0 = nstops;
    repeat (4000) if (nstops === n0) @(posedge clock);
    repeat (12) @(posedge clock);
    // step off the edge so registered outputs are read settled
    #1;
    chk(32'(nstops - n0), 32'h1, "one stop per frame");
  endtask
  task automatic t_reset;
    logic [5:0] zl [7];
    zl = '{A_MMR, A_INTERNAL_ADDR_BYTES, A_CWGR, A_IMR, A_RHR, A_THR, 6'h08};
    rchk(A_SR, '1, 32'h8, "status reset");
    foreach (zl[i]) rchk(zl[i], '1, 32'h0, "reset or unmapped zero");
    wr_reg(6'h08, '1);
    rchk(6'h08, '1, 32'h0, "unmapped write ignored");
    wr_reg(A_MMR, '1);
    rchk(A_MMR, '1, 32'h007f1300, "mode fields");
    $display("test reset done");
  endtask
  task automatic t_irq;
    wr_reg(A_IER, '1);
    rchk(A_IMR, '1, 32'h1c7, "mask set");
    wr_reg(A_IDR, 32'hc3);
    rchk(A_IMR, '1, 32'h104, "mask clear");
    wr_reg(A_CR, 32'h4);
    rchk(A_SR, '1, 32'hd, "enable status");
    chk(32'(irq), 32'h1, "irq on enabled flag");
    wr_reg(A_IDR, 32'h4);
    repeat (2) @(posedge clock);
    #1;
    chk(32'(irq), 32'h0, "irq masked");
    $display("test irq done");
  endtask
  task automatic t_write;
    wr_reg(A_MMR, 32'h00500200);
    wr_reg(A_INTERNAL_ADDR_BYTES, 32'h1234);
    wr_reg(A_CWGR, 32'h10102);
    wr_reg(A_THR, 32'ha5);
    repeat (20) @(posedge clock);
    rchk(A_SR, 32'h5, 32'h0, "busy flags");
    wait_stop();
    chk(last4, 32'ha01234a5, "write frame bytes");
    rchk(A_SR, '1, 32'h8d, "write end status");
    rchk(A_SR, 32'h80, 32'h0, "underrun cleared");
    chk(32'(low_run), 32'h7, "low period");
    chk(32'(high_run), 32'h5, "high period");
    wr_reg(A_CWGR, 32'h0);
    $display("test write done");
  endtask
  task automatic t_read;
    wr_reg(A_MMR, 32'h00501000);
    rd_byte = 8'h3c;
    wr_reg(A_CR, 32'h3);
    wait_stop();
    chk(last4 & 32'hffff, 32'ha13c, "read frame");
    rchk(A_SR, '1, 32'hf, "rx ready");
    wr_reg(A_CR, 32'h3);
    wait_stop();
    rchk(A_SR, 32'h42, 32'h42, "overrun set");
    rchk(A_SR, 32'h40, 32'h0, "overrun cleared");
    rchk(A_RHR, '1, 32'h3c, "received byte");
    rchk(A_SR, 32'h2, 32'h0, "rx ready cleared");
    $display("test read done");
  endtask
  task automatic t_nack;
    ack_en = 1'b0;
    wr_reg(A_MMR, 32'h00500000);
    wr_reg(A_THR, 32'h5a);
    wait_stop();
    chk(32'(irq), 32'h1, "irq on nack");
    rchk(A_SR, 32'h105, 32'h105, "nack status");
    rchk(A_SR, 32'h100, 32'h0, "nack cleared");
    ack_en = 1'b1;
    $display("test nack done");
  endtask
  task automatic t_ctl;
    wr_reg(A_CR, 32'h80);
    rchk(A_MMR, '1, 32'h0, "soft reset mode");
    rchk(A_IMR, '1, 32'h0, "soft reset mask");
    rchk(A_SR, '1, 32'h8, "soft reset status");
    wr_reg(A_CR, 32'hc);
    rchk(A_SR, '1, 32'h8, "enable with disable");
    n0 = nbytes;
    wr_reg(A_THR, 32'h11);
    repeat (100) @(posedge clock);
    chk(32'(nbytes), 32'(n0), "no frame while disabled");
    wr_reg(A_CR, 32'h4);
    wr_reg(A_MMR, 32'h00500000);
    wr_reg(A_THR, 32'h77);
    wr_reg(A_CR, 32'h8);
    wait_stop();
    chk(last4 & 32'hffff, 32'ha077, "drained before disable");
    n0 = nbytes;
    wr_reg(A_THR, 32'h22);
    repeat (100) @(posedge clock);
    chk(32'(nbytes), 32'(n0), "disabled after drain");
    $display("test control done");
  endtask
  task automatic final_report;
    $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {nrst, wr, rd, addr, wdata} = '0;
    ack_en = 1'b1;
    rd_byte = 8'h00;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_irq();
    t_write();
    t_read();
    t_nack();
    t_ctl();
    final_report();
  end
endmodule

// File: hw/twm_pkg.sv
// constants, state types and field layout of the two-wire master register block
// assumes a 20 MHz master clock and a plain strobed register port
// Function
// - start command begins a frame using the master mode settings; needed for reads
// - in write direction, writing transmit holding starts the frame automatically
// - stop command issues a stop after the byte now in transfer
// - in read mode the not-acknowledge of the last byte brings an automatic stop
// - write frame sends stop once holding and shift registers are both empty
// - enable bit enables transfers unless disable is written in the same access
// - disable waits for pending work: held bytes sent, current read byte finished
// - soft reset bit resets the block as system reset does, except the pin synchronisers, which keep sampling
// - two-bit size field selects zero to three internal address bytes
// - direction bit: zero means master write, one means master read
// - device address field is the slave address sent after start
// - internal address register supplies the internal address bytes, low byte last
// - clock low and high times are divider shifted by exponent plus three cycles
// - transfer done is low during a frame, set after stop or on enable; an enable written with start while enabled keeps it high for that frame
// - receive ready is set when a byte lands in receive holding
// - transmit ready clears on holding write, sets on load, nack, enable
// - overrun sets when receive holding reloads while ready; status read clears it while transfer done is set
// - underrun sets when shifter needs data but holding is empty; stop follows
// - not-acknowledged sets with transfer done and clears on status read
// - enable and disable writes set or clear mask bits; mask reads back
// - reading receive holding clears receive ready
package twm_pkg;
  localparam logic [5:0] A_CR = 6'h00;
  localparam logic [5:0] A_MMR = 6'h04;
  localparam logic [5:0] A_INTERNAL_ADDR_BYTES = 6'h0c;
  localparam logic [5:0] A_CWGR = 6'h10;
  localparam logic [5:0] A_SR = 6'h20;
  localparam logic [5:0] A_IER = 6'h24;
  localparam logic [5:0] A_IDR = 6'h28;
  localparam logic [5:0] A_IMR = 6'h2c;
  localparam logic [5:0] A_RHR = 6'h30;
  localparam logic [5:0] A_THR = 6'h34;
  localparam int B_START = 0;
  localparam int B_STOP = 1;
  localparam int B_MASTER_ENABLE = 2;
  localparam int B_MASTER_DISABLE = 3;
  localparam int B_SOFT_RESET_CMD = 7;
  localparam int F_IASZ = 8;
  localparam int F_RDIR = 12;
  localparam int F_SLAVE_SELECT_ADDRESS = 16;
  localparam int F_CL = 0;
  localparam int F_CH = 8;
  localparam int F_CK = 16;
  localparam int S_TRANSFER_DONE = 0;
  localparam int S_RECEIVE_READY = 1;
  localparam int S_TRANSMIT_READY = 2;
  localparam int S_OVERRUN_FLAG = 6;
  localparam int S_UNDERRUN_FLAG = 7;
  localparam int S_NACK = 8;
  localparam logic [8:0] SR_RST = 9'h008;
  localparam logic [8:0] SRC_MASK = 9'h1c7;
  localparam logic [15:0] SCL_ADD = 16'h0003;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BYTE, ST_STOP} twm_state_t;
  typedef enum logic [2:0] {K_ADDR, K_INTERNAL_ADDR_BYTES, K_ARD, K_TX, K_RX} twm_kind_t;
  typedef enum logic [1:0] {N_BYTE, N_RS, N_STOP} twm_next_t;
endpackage

// File: hw/twm_regs.sv
// two-wire bus master: register file, frame sequencer and clock generator
// assumes open-drain pads outside; pins arrive asynchronous and are synchronised here
`timescale 1ns/10ps
module twm_regs import twm_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  logic srst;
  logic cr_wr;
  logic thr_wr;
  logic sr_rd;
  logic rhr_rd;
  logic en_cmd;
  logic dis_cmd;
  logic [6:0] slave_select_address_r;
  logic rdir_r;
  logic [1:0] iasz_r;
  logic [23:0] internal_addr_bytes_r;
  logic [7:0] cl_r;
  logic [7:0] ch_r;
  logic [2:0] ck_r;
  logic [7:0] thr_r;
  logic [7:0] rhr_r;
  logic [7:0] sh_r;
  logic en_r;
  logic dis_r;
  logic stp_r;
  logic nkp_r;
  logic transfer_done_r;
  logic receive_ready_r;
  logic transmit_ready_r;
  logic overrun_flag_r;
  logic underrun_flag_r;
  logic nack_r;
  logic [8:0] mask_r;
  logic [8:0] sr_v;
  logic [31:0] rv;
  logic [31:0] rdata_r;
  logic irq_r;
  logic scl_m_r;
  logic scl_s_r;
  logic sda_m_r;
  logic sda_s_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic pin_lo_r;
  twm_state_t st_r;
  twm_kind_t kd_r;
  twm_kind_t nk;
  twm_next_t nact;
  logic [7:0] nsh;
  logic [1:0] nidx;
  logic [1:0] ph_r;
  logic [1:0] idx_r;
  logic [3:0] bit_r;
  logic [15:0] cnt_r;
  logic [15:0] t_lo;
  logic [15:0] t_hi;
  logic tick;
  logic go;
  logic done;
  logic nak;
  logic want_ld;
  logic ld_ok;
  logic ld_und;
  logic rx_done;
  logic stop_done;
  logic last_rx;

  assign cr_wr = wr && addr == A_CR;
  assign thr_wr = wr && addr == A_THR;
  assign sr_rd = rd && addr == A_SR;
  assign rhr_rd = rd && addr == A_RHR;
  assign srst = cr_wr && wdata[B_SOFT_RESET_CMD];
  assign en_cmd = cr_wr && wdata[B_MASTER_ENABLE] && !wdata[B_MASTER_DISABLE];
  assign dis_cmd = cr_wr && wdata[B_MASTER_DISABLE];

  assign t_lo = ({8'h00, cl_r} << ck_r) + SCL_ADD;
  assign t_hi = ({8'h00, ch_r} << ck_r) + SCL_ADD;
  // a slave holding the clock low stretches the high phase
  assign tick = cnt_r == 16'h0000 && (scl_oe_r || scl_s_r);
  assign go = st_r == ST_IDLE && en_r && !dis_r &&
      ((cr_wr && wdata[B_START]) || (thr_wr && !rdir_r));
  assign done = st_r == ST_BYTE && ph_r == 2'd1 && bit_r == 4'd8 && tick;
  assign nak = kd_r != K_RX && sda_s_r;
  assign last_rx = stp_r || dis_r;
  assign rx_done = done && kd_r == K_RX;
  assign stop_done = st_r == ST_STOP && ph_r == 2'd2 && tick;
  assign ld_ok = done && want_ld && !transmit_ready_r;
  assign ld_und = done && want_ld && transmit_ready_r;

  always_comb begin
    nk = kd_r;
    nsh = sh_r;
    nidx = idx_r;
    nact = N_STOP;
    want_ld = 1'b0;
    if (!nak) begin
      unique case (kd_r)
        K_ADDR: begin
          if (iasz_r != 2'b00) begin
            nk = K_INTERNAL_ADDR_BYTES;
            nidx = iasz_r - 2'd1;
            nsh = internal_addr_bytes_r[{nidx, 3'b000} +: 8];
            nact = N_BYTE;
          end else if (rdir_r) begin
            nk = K_RX;
            nact = N_BYTE;
          end else begin
            want_ld = 1'b1;
          end
        end
        K_INTERNAL_ADDR_BYTES: begin
          if (idx_r != 2'd0) begin
            nidx = idx_r - 2'd1;
            nsh = internal_addr_bytes_r[{nidx, 3'b000} +: 8];
            nact = N_BYTE;
          end else if (rdir_r) begin
            nk = K_ARD;
            nsh = {slave_select_address_r, 1'b1};
            nact = N_RS;
          end else begin
            want_ld = 1'b1;
          end
        end
        K_ARD: begin
          nk = K_RX;
          nact = N_BYTE;
        end
        K_TX: begin
          want_ld = !stp_r;
        end
        K_RX: begin
          if (!last_rx) begin
            nact = N_BYTE;
          end
        end
      endcase
      if (want_ld && !transmit_ready_r) begin
        nk = K_TX;
        nsh = thr_r;
        nact = N_BYTE;
      end
    end
  end

  // frame sequencer and serial pin drive
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      kd_r <= K_ADDR;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      idx_r <= 2'd0;
      sh_r <= 8'h00;
      cnt_r <= 16'h0000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (srst) begin
      st_r <= ST_IDLE;
      kd_r <= K_ADDR;
      ph_r <= 2'd0;
      bit_r <= 4'd0;
      idx_r <= 2'd0;
      sh_r <= 8'h00;
      cnt_r <= 16'h0000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      unique case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r <= ST_START;
            ph_r <= 2'd2;
            kd_r <= K_ADDR;
            idx_r <= 2'd0;
            sh_r <= {slave_select_address_r, rdir_r && iasz_r == 2'b00};
            sda_oe_r <= 1'b1;
            cnt_r <= t_hi - 16'h0001;
          end
        end
        ST_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'd1;
            if (ph_r == 2'd0) begin
              scl_oe_r <= 1'b0;
              cnt_r <= t_hi - 16'h0001;
            end else if (ph_r == 2'd1) begin
              sda_oe_r <= 1'b1;
              cnt_r <= t_hi - 16'h0001;
            end else begin
              st_r <= ST_BYTE;
              ph_r <= 2'd0;
              bit_r <= 4'd0;
              scl_oe_r <= 1'b1;
              sda_oe_r <= kd_r != K_RX && !sh_r[7];
              cnt_r <= t_lo - 16'h0001;
            end
          end
        end
        ST_BYTE: begin
          if (tick && ph_r == 2'd0) begin
            ph_r <= 2'd1;
            scl_oe_r <= 1'b0;
            cnt_r <= t_hi - 16'h0001;
          end else if (tick && bit_r != 4'd8) begin
            sh_r <= {sh_r[6:0], sda_s_r};
            bit_r <= bit_r + 4'd1;
            ph_r <= 2'd0;
            scl_oe_r <= 1'b1;
            cnt_r <= t_lo - 16'h0001;
            if (bit_r == 4'd7) begin
              sda_oe_r <= kd_r == K_RX && !last_rx;
            end else begin
              sda_oe_r <= kd_r != K_RX && !sh_r[6];
            end
          end else if (done) begin
            kd_r <= nk;
            sh_r <= nsh;
            idx_r <= nidx;
            ph_r <= 2'd0;
            bit_r <= 4'd0;
            scl_oe_r <= 1'b1;
            cnt_r <= t_lo - 16'h0001;
            unique case (nact)
              N_BYTE: sda_oe_r <= nk != K_RX && !nsh[7];
              N_RS: begin
                st_r <= ST_START;
                sda_oe_r <= 1'b0;
              end
              N_STOP: begin
                st_r <= ST_STOP;
                sda_oe_r <= 1'b1;
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'd1;
            cnt_r <= t_hi - 16'h0001;
            if (ph_r == 2'd0) begin
              scl_oe_r <= 1'b0;
            end else if (ph_r == 2'd1) begin
              sda_oe_r <= 1'b0;
            end else begin
              st_r <= ST_IDLE;
              ph_r <= 2'd0;
            end
          end
        end
      endcase
    end
  end

  // pins are asynchronous to the master clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      pin_lo_r <= 1'b0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      pin_lo_r <= 1'b0;
    end
  end

  // mode, address, clock and holding registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slave_select_address_r <= 7'h00;
      rdir_r <= 1'b0;
      iasz_r <= 2'b00;
      internal_addr_bytes_r <= 24'h000000;
      cl_r <= 8'h00;
      ch_r <= 8'h00;
      ck_r <= 3'h0;
      thr_r <= 8'h00;
      rhr_r <= 8'h00;
    end else if (srst) begin
      slave_select_address_r <= 7'h00;
      rdir_r <= 1'b0;
      iasz_r <= 2'b00;
      internal_addr_bytes_r <= 24'h000000;
      cl_r <= 8'h00;
      ch_r <= 8'h00;
      ck_r <= 3'h0;
      thr_r <= 8'h00;
      rhr_r <= 8'h00;
    end else begin
      if (wr && addr == A_MMR) begin
        slave_select_address_r <= wdata[F_SLAVE_SELECT_ADDRESS +: 7];
        rdir_r <= wdata[F_RDIR];
        iasz_r <= wdata[F_IASZ +: 2];
      end
      if (wr && addr == A_INTERNAL_ADDR_BYTES) begin
        internal_addr_bytes_r <= wdata[23:0];
      end
      if (wr && addr == A_CWGR) begin
        cl_r <= wdata[F_CL +: 8];
        ch_r <= wdata[F_CH +: 8];
        ck_r <= wdata[F_CK +: 3];
      end
      if (thr_wr) begin
        thr_r <= wdata[7:0];
      end
      if (rx_done) begin
        rhr_r <= sh_r;
      end
    end
  end

  // enable, pending disable, pending stop, pending nack
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      dis_r <= 1'b0;
      stp_r <= 1'b0;
      nkp_r <= 1'b0;
    end else if (srst) begin
      en_r <= 1'b0;
      dis_r <= 1'b0;
      stp_r <= 1'b0;
      nkp_r <= 1'b0;
    end else begin
      if (en_cmd) begin
        en_r <= 1'b1;
        dis_r <= 1'b0;
      end else if (dis_cmd && st_r == ST_IDLE) begin
        en_r <= 1'b0;
      end else if (dis_cmd) begin
        dis_r <= 1'b1;
      end else if (stop_done && dis_r) begin
        en_r <= 1'b0;
        dis_r <= 1'b0;
      end
      if (cr_wr && wdata[B_STOP] && (st_r != ST_IDLE || wdata[B_START])) begin
        stp_r <= 1'b1;
      end else if (stop_done) begin
        stp_r <= 1'b0;
      end
      if (done && nak) begin
        nkp_r <= 1'b1;
      end else if (stop_done) begin
        nkp_r <= 1'b0;
      end
    end
  end

  // status flags: a hardware set wins over a software clear, except transmit ready, where a holding write wins over a load
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      transfer_done_r <= SR_RST[S_TRANSFER_DONE];
      receive_ready_r <= SR_RST[S_RECEIVE_READY];
      transmit_ready_r <= SR_RST[S_TRANSMIT_READY];
      overrun_flag_r <= SR_RST[S_OVERRUN_FLAG];
      underrun_flag_r <= SR_RST[S_UNDERRUN_FLAG];
      nack_r <= SR_RST[S_NACK];
    end else if (srst) begin
      transfer_done_r <= SR_RST[S_TRANSFER_DONE];
      receive_ready_r <= SR_RST[S_RECEIVE_READY];
      transmit_ready_r <= SR_RST[S_TRANSMIT_READY];
      overrun_flag_r <= SR_RST[S_OVERRUN_FLAG];
      underrun_flag_r <= SR_RST[S_UNDERRUN_FLAG];
      nack_r <= SR_RST[S_NACK];
    end else begin
      if (stop_done || (en_cmd && st_r == ST_IDLE)) begin
        transfer_done_r <= 1'b1;
      end else if (go) begin
        transfer_done_r <= 1'b0;
      end
      if (rx_done) begin
        receive_ready_r <= 1'b1;
      end else if (rhr_rd) begin
        receive_ready_r <= 1'b0;
      end
      // a holding write beats a same-cycle load so the new byte is not lost
      if (thr_wr) begin
        transmit_ready_r <= 1'b0;
      end else if (ld_ok || (stop_done && nkp_r) || en_cmd) begin
        transmit_ready_r <= 1'b1;
      end
      if (rx_done && receive_ready_r) begin
        overrun_flag_r <= 1'b1;
      end else if (sr_rd && transfer_done_r) begin
        overrun_flag_r <= 1'b0;
      end
      if (ld_und) begin
        underrun_flag_r <= 1'b1;
      end else if (sr_rd && transfer_done_r) begin
        underrun_flag_r <= 1'b0;
      end
      if (stop_done && nkp_r) begin
        nack_r <= 1'b1;
      end else if (sr_rd) begin
        nack_r <= 1'b0;
      end
    end
  end

  always_comb begin
    sr_v = SR_RST & ~SRC_MASK;
    sr_v[S_TRANSFER_DONE] = transfer_done_r;
    sr_v[S_RECEIVE_READY] = receive_ready_r;
    sr_v[S_TRANSMIT_READY] = transmit_ready_r;
    sr_v[S_OVERRUN_FLAG] = overrun_flag_r;
    sr_v[S_UNDERRUN_FLAG] = underrun_flag_r;
    sr_v[S_NACK] = nack_r;
    rv = 32'h00000000;
    unique case (addr)
      A_MMR: begin
        rv[F_SLAVE_SELECT_ADDRESS +: 7] = slave_select_address_r;
        rv[F_RDIR] = rdir_r;
        rv[F_IASZ +: 2] = iasz_r;
      end
      A_INTERNAL_ADDR_BYTES: rv[23:0] = internal_addr_bytes_r;
      A_CWGR: begin
        rv[F_CL +: 8] = cl_r;
        rv[F_CH +: 8] = ch_r;
        rv[F_CK +: 3] = ck_r;
      end
      A_SR: rv[8:0] = sr_v;
      A_IMR: rv[8:0] = mask_r;
      A_RHR: rv[7:0] = rhr_r;
      A_THR: rv[7:0] = thr_r;
      default: rv = 32'h00000000;
    endcase
  end

  // mask, read port and interrupt line
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_r <= 9'h000;
      rdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else if (srst) begin
      mask_r <= 9'h000;
      rdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else begin
      if (wr && addr == A_IER) begin
        mask_r <= mask_r | (wdata[8:0] & SRC_MASK);
      end else if (wr && addr == A_IDR) begin
        mask_r <= mask_r & ~wdata[8:0];
      end
      rdata_r <= rd ? rv : 32'h00000000;
      irq_r <= |(sr_v & mask_r);
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign scl_out = pin_lo_r;
  assign sda_out = pin_lo_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || srst);

  sequence start_edge_s;
    st_r == ST_START && sda_oe_r && !scl_oe_r;
  endsequence

  start_cmd_a: assert property (cr_wr && wdata[B_START] && go |=> start_edge_s)
    else $error("start command did not open a frame");
  thr_start_a: assert property (thr_wr && go && !cr_wr |=> start_edge_s)
    else $error("holding write did not open a frame");
  rx_stop_a: assert property (rx_done && last_rx |=> st_r == ST_STOP ##0 sda_oe_r)
    else $error("last read byte not followed by stop");
  empty_stop_a: assert property (ld_und |=> st_r == ST_STOP ##1 underrun_flag_r)
    else $error("empty holding did not stop the write");
  enable_cmd_a: assert property (en_cmd |=> en_r && transmit_ready_r)
    else $error("enable command ignored");
  idle_dis_a: assert property (dis_cmd && !en_cmd && st_r == ST_IDLE |=> !en_r)
    else $error("disable while idle ignored");
  soft_rst_a: assert property (@(posedge clock) disable iff (!nrst)
      srst |=> st_r == ST_IDLE && mask_r == 9'h000 && !scl_oe_r)
    else $error("soft reset left state behind");
  scl_low_a: assert property ($rose(scl_oe_r) |-> cnt_r == t_lo - 16'h0001)
    else $error("clock low period wrong");
  busy_comp_a: assert property (st_r != ST_IDLE |-> !transfer_done_r)
    else $error("transfer done high during frame");
  thr_clr_a: assert property (thr_wr |=> !transmit_ready_r)
    else $error("transmit ready not cleared by write");
  overrun_a: assert property (rx_done && receive_ready_r |=> overrun_flag_r && receive_ready_r)
    else $error("overrun missed");
  nack_flag_a: assert property (stop_done && nkp_r |=> nack_r && transfer_done_r && transmit_ready_r)
    else $error("nack not flagged with completion");
  rhr_clr_a: assert property (rhr_rd && !rx_done |=> !receive_ready_r)
    else $error("receive ready not cleared by read");
  irq_out_a: assert property ((|(sr_v & mask_r)) [*2] |-> irq_r)
    else $error("interrupt not raised");
endmodule
